//--- core/ccdw_window.sv
// Black reference and active pixel window generator with register slave
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module ccdw_window (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // Pixel timing
    input  wire logic                          pix_en,
    input  wire logic                          frame_start,
    input  wire logic [ccdw_pkg::POS_W-1:0]    line_len,
    input  wire logic [ccdw_pkg::POS_W-1:0]    frame_rows,
    input  wire logic [3:0]                    black_start,
    // Classic Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ccdw_pkg::ADR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [ccdw_pkg::DAT_W-1:0]    wb_dat_i,
    output logic      [ccdw_pkg::DAT_W-1:0]    wb_dat_o,
    output logic                               wb_ack_o,
    // Window outputs
    output logic                               out_clock_pin,
    output logic                               black_window,
    output logic                               black_line_rearm
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [6:0] black_end_column;
    logic [7:0] inactive_row_bands;
    logic [7:0] active_start_column;
    logic       valid_mode;
    logic       clk_toggle;

    // ------------------------------------------------------------
    // Position
    // ------------------------------------------------------------
    wire logic [ccdw_pkg::POS_W-1:0] col;
    wire logic [ccdw_pkg::POS_W-1:0] row;

    ccdw_pos_counter u_pos (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .pix_en      (pix_en),
        .frame_start (frame_start),
        .line_len    (line_len),
        .frame_rows  (frame_rows),
        .col         (col),
        .row         (row)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Word access only; the two low address bits are ignored
    wire logic       bus_req;
    wire logic       bus_wr;
    wire logic       lane0_wr;
    wire logic [5:0] reg_idx;
    wire logic       hit_black_end;
    wire logic       hit_row_bands;
    wire logic       hit_active;
    wire logic       hit_mode;
    wire logic       hit_status;
    wire logic [ccdw_pkg::DAT_W-1:0] rd_data;
    wire logic [ccdw_pkg::DAT_W-1:0] status_word;

    assign bus_req       = wb_cyc_i && wb_stb_i;
    assign bus_wr        = bus_req && wb_we_i && wb_ack_o;
    assign lane0_wr      = bus_wr && wb_sel_i[0];
    assign reg_idx       = wb_adr_i[ccdw_pkg::ADR_W-1:2];
    assign hit_black_end = (reg_idx == ccdw_pkg::IDX_BLACK_END);
    assign hit_row_bands = (reg_idx == ccdw_pkg::IDX_ROW_BANDS);
    assign hit_active    = (reg_idx == ccdw_pkg::IDX_ACTIVE_START);
    assign hit_mode      = (reg_idx == ccdw_pkg::IDX_MODE_CTRL);
    assign hit_status    = (reg_idx == ccdw_pkg::IDX_POS_STATUS);

    assign status_word =
        (32'(row) << ccdw_pkg::STAT_ROW_LSB)
        | (32'(col) << ccdw_pkg::STAT_COL_LSB);

    // Unmapped addresses still answer, with zero data
    assign rd_data =
        hit_black_end ? {25'h000_0000, black_end_column} :
        hit_row_bands ? {24'h00_0000, inactive_row_bands} :
        hit_active    ? {24'h00_0000, active_start_column} :
        hit_mode      ? {31'h0000_0000, valid_mode} :
        hit_status    ? status_word :
                        32'h0000_0000;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Ack in the cycle after the request, then low for one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= (bus_req && !wb_ack_o) ? rd_data : wb_dat_o;
        end
    end

    // ------------------------------------------------------------
    // Register writes, at the edge that completes the cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            black_end_column    <= ccdw_pkg::RST_BLACK_END;
            inactive_row_bands  <= ccdw_pkg::RST_ROW_BANDS;
            active_start_column <= ccdw_pkg::RST_ACTIVE_START;
            valid_mode          <= ccdw_pkg::RST_VALID_MODE;
        end else if (lane0_wr) begin
            if (hit_black_end) begin
                black_end_column <=
                    wb_dat_i[ccdw_pkg::BLACK_END_MSB:0];
            end
            if (hit_row_bands) begin
                inactive_row_bands <= wb_dat_i[7:0];
            end
            if (hit_active) begin
                active_start_column <= wb_dat_i[7:0];
            end
            if (hit_mode) begin
                valid_mode <= wb_dat_i[ccdw_pkg::VALID_MODE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    // No clamping of odd settings: overlapping bands simply give no
    // valid rows, and a low active start lets dark pixels through
    wire logic [3:0]                 lead_rows;
    wire logic [3:0]                 trail_rows;
    wire logic [ccdw_pkg::POS_W-1:0] trail_first;
    wire logic                       past_lead;
    wire logic                       before_trail;
    wire logic                       past_start;
    wire logic                       valid_term;
    wire logic                       black_term;
    wire logic                       black_last;

    assign lead_rows  = inactive_row_bands[ccdw_pkg::LEAD_ROWS_MSB:
                                           ccdw_pkg::LEAD_ROWS_LSB];
    assign trail_rows = inactive_row_bands[ccdw_pkg::TRAIL_ROWS_MSB:
                                           ccdw_pkg::TRAIL_ROWS_LSB];
    assign trail_first = (frame_rows > 13'(trail_rows)) ?
                         frame_rows - 13'(trail_rows) : '0;
    assign past_lead    = (row >= 13'(lead_rows));
    assign before_trail = (row < trail_first);
    assign past_start   = (col >= 13'(active_start_column));
    assign valid_term   = past_lead && before_trail && past_start;

    assign black_term = (col >= 13'(black_start))
                        && (col <= 13'(black_end_column));
    assign black_last = pix_en && (col == 13'(black_end_column));

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Outside valid-data mode the pin toggles at half the pixel rate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_toggle <= 1'b0;
        end else if (pix_en) begin
            clk_toggle <= !clk_toggle;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_clock_pin    <= 1'b0;
            black_window     <= 1'b0;
            black_line_rearm <= 1'b0;
        end else begin
            out_clock_pin    <= valid_mode ? valid_term : clk_toggle;
            black_window     <= black_term;
            black_line_rearm <= black_last;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    black_end_rst_a: assert property (
        $fell(sys_rst) |-> black_end_column == 7'h3f
                           && wb_dat_o[31:8] == 24'h00_0000)
        else $error("black end column not at reset value");

    black_span_a: assert property (
        col == 13'(black_start) && col <= 13'(black_end_column)
        |=> black_window)
        else $error("black window missing at black start column");

    black_rearm_a: assert property (
        black_line_rearm |-> $past(col) == 13'($past(black_end_column))
                             && $past(pix_en))
        else $error("black loop rearmed at wrong column");

    lead_rows_a: assert property (
        valid_mode && row < 13'(inactive_row_bands[7:4])
        ##1 valid_mode |-> !out_clock_pin)
        else $error("data valid during leading rows");

    trail_rows_a: assert property (
        valid_mode && frame_rows > 13'(inactive_row_bands[3:0])
        && row >= frame_rows - 13'(inactive_row_bands[3:0])
        ##1 valid_mode |-> !out_clock_pin)
        else $error("data valid during trailing rows");

    active_col_a: assert property (
        valid_mode && col < 13'(active_start_column)
        ##1 valid_mode |-> !out_clock_pin)
        else $error("data valid before active start column");

    valid_pin_a: assert property (
        valid_mode ##1 valid_mode |-> out_clock_pin == $past(valid_term))
        else $error("clock pin does not follow data valid");

    valid_subset_a: assert property (
        valid_mode && past_lead && before_trail && past_start
        ##1 valid_mode |-> out_clock_pin)
        else $error("data valid missing inside window");

    dark_allowed_a: assert property (
        valid_mode && lead_rows == 4'h0 && row == '0 && past_start
        && before_trail ##1 valid_mode |-> out_clock_pin)
        else $error("dark rows not passed when selected");

    bus_ack_a: assert property (
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle pulse");

    valid_seen_c: cover property (valid_mode && $rose(out_clock_pin));
    rearm_seen_c: cover property (black_line_rearm);
    write_seen_c: cover property (lane0_wr && hit_row_bands);
    frame_wrap_c: cover property ($fell(past_lead));

endmodule

`default_nettype wire

//--- core/ccdw_pkg.sv
// Constants shared by the black and active pixel window logic
package ccdw_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned POS_W = 13;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_BLACK_END    = 6'h1d;
    localparam logic [5:0] IDX_ROW_BANDS    = 6'h1e;
    localparam logic [5:0] IDX_ACTIVE_START = 6'h1f;
    localparam logic [5:0] IDX_MODE_CTRL    = 6'h30;
    localparam logic [5:0] IDX_POS_STATUS   = 6'h31;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RST_BLACK_END    = 7'h3f;
    localparam logic [7:0] RST_ROW_BANDS    = 8'hc6;
    localparam logic [7:0] RST_ACTIVE_START = 8'h4b;
    localparam logic       RST_VALID_MODE   = 1'b0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned BLACK_END_MSB  = 6;
    localparam int unsigned LEAD_ROWS_MSB  = 7;
    localparam int unsigned LEAD_ROWS_LSB  = 4;
    localparam int unsigned TRAIL_ROWS_MSB = 3;
    localparam int unsigned TRAIL_ROWS_LSB = 0;
    localparam int unsigned VALID_MODE_BIT = 0;
    localparam int unsigned STAT_COL_LSB   = 0;
    localparam int unsigned STAT_ROW_LSB   = 16;

endpackage

//--- core/ccdw_pos_counter.sv
// Column and row position counter for one frame of pixels
`timescale 1ns/1ps
`default_nettype none

module ccdw_pos_counter (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          pix_en,
    input  wire logic                          frame_start,
    input  wire logic [ccdw_pkg::POS_W-1:0]    line_len,
    input  wire logic [ccdw_pkg::POS_W-1:0]    frame_rows,
    output logic      [ccdw_pkg::POS_W-1:0]    col,
    output logic      [ccdw_pkg::POS_W-1:0]    row
);

    // ------------------------------------------------------------
    // Wrap points
    // ------------------------------------------------------------
    // A length of zero is treated as one so the counters never run away
    wire logic [ccdw_pkg::POS_W-1:0] last_col;
    wire logic [ccdw_pkg::POS_W-1:0] last_row;
    wire logic                       col_wrap;
    wire logic                       row_wrap;
    wire logic [ccdw_pkg::POS_W-1:0] next_col;
    wire logic [ccdw_pkg::POS_W-1:0] next_row;

    assign last_col = (line_len == '0) ? '0 : line_len - 1'b1;
    assign last_row = (frame_rows == '0) ? '0 : frame_rows - 1'b1;
    assign col_wrap = (col >= last_col);
    assign row_wrap = (row >= last_row);
    assign next_col = col_wrap ? '0 : col + 1'b1;
    assign next_row = !col_wrap ? row : (row_wrap ? '0 : row + 1'b1);

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || frame_start) begin
            col <= '0;
            row <= '0;
        end else if (pix_en) begin
            col <= next_col;
            row <= next_row;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    col_wrap_pos_a: assert property (
        pix_en && !frame_start && col_wrap |=> col == '0)
        else $error("column did not wrap at line length");

    col_step_a: assert property (
        pix_en && !frame_start && !col_wrap |=> col == $past(col) + 1'b1)
        else $error("column did not advance by one");

endmodule

`default_nettype wire

//--- test/ccdw_sink.sv
// Downstream processor model that takes the pixels flagged as valid
`timescale 1ns/1ps
`default_nettype none

module ccdw_sink (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        data_valid,
    output logic      [15:0] valid_count
);
    // ------------------------------------------------------------
    // Pixel intake
    // ------------------------------------------------------------
    // Takes every flagged pixel, dark ones too, as the window allows
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_count <= 16'h0000;
        end else if (data_valid) begin
            valid_count <= valid_count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- test/tb_ccdw_window.sv
// Self-checking bench for the black and active pixel window block
`timescale 1ns/1ps
`default_nettype none

module tb_ccdw_window;
    // ------------------------------------------------------------
    // Nets, design and partner
    // ------------------------------------------------------------
    // One row per case: lead rows, trail rows, active start, and the
    // number of pixels that should be flagged valid over two frames
    typedef struct {logic [3:0] lead; logic [3:0] trail;
                    logic [7:0] act; logic [15:0] n_valid;} ccdw_cfg_s;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        pix_en = 1'b0;
    logic        frame_start = 1'b0;
    logic [12:0] line_len = 13'h0008;
    logic [12:0] frame_rows = 13'h0006;
    logic [3:0]  black_start = 4'h2;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        out_clock_pin;
    logic        black_window;
    logic        black_line_rearm;
    logic [15:0] valid_count;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;
    ccdw_cfg_s   cfg [4] = '{'{4'h2, 4'h1, 8'h03, 16'h001e},
                             '{4'h0, 4'h0, 8'h00, 16'h0060},
                             '{4'h1, 4'h7, 8'h02, 16'h0000},
                             '{4'h1, 4'h1, 8'h07, 16'h0008}};

    always #12.5 clk = ~clk;

    ccdw_window uut (.clk(clk), .sys_rst(sys_rst), .pix_en(pix_en),
        .frame_start(frame_start), .line_len(line_len),
        .frame_rows(frame_rows), .black_start(black_start),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .out_clock_pin(out_clock_pin), .black_window(black_window),
        .black_line_rearm(black_line_rearm));

    ccdw_sink sink (.clk(clk), .sys_rst(sys_rst),
        .data_valid(out_clock_pin), .valid_count(valid_count));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Holds the request until ack is seen high at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        wb_sel <= sel;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        // Ack is seen at this edge: data is taken and the request dropped
        rd = wb_dat_o;
        check(32'(wb_ack_o), 32'h0000_0001, "bus answer");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic check_reset_values();
        logic [7:0]  adr [6] = '{8'h74, 8'h78, 8'h7c, 8'hc0, 8'hc4, 8'h10};
        logic [31:0] val [6];
        val = '{32'(ccdw_pkg::RST_BLACK_END), 32'(ccdw_pkg::RST_ROW_BANDS),
                32'(ccdw_pkg::RST_ACTIVE_START),
                32'(ccdw_pkg::RST_VALID_MODE), 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, adr[i], 32'h0000_0000, 4'hf);
            check(rd, val[i], "reset value");
        end
    endtask

    // Two whole frames, all three window outputs compared each pixel
    task automatic run_cfg(input ccdw_cfg_s g);
        int c;
        int r;
        int want;
        logic [15:0] base;
        wb(1'b1, 8'h78, {24'h00_0000, g.lead, g.trail}, 4'h1);
        wb(1'b1, 8'h7c, {24'h00_0000, g.act}, 4'h1);
        wb(1'b1, 8'hc0, 32'h0000_0001, 4'h1);
        @(posedge clk);
        frame_start <= 1'b1;
        pix_en <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        want = 0;
        for (int k = 0; k < 96; k++) begin
            c = k % 8;
            r = (k / 8) % 6;
            @(posedge clk);
            #1;
            if (k == 0) base = valid_count;
            if (r >= g.lead && r + g.trail < 6 && c >= g.act) want++;
            check(32'(out_clock_pin), 32'(r >= g.lead && r + g.trail < 6
                  && c >= g.act), "data valid");
            check(32'(black_window), 32'(c >= 2 && c <= 5), "black");
            check(32'(black_line_rearm), 32'(c == 5), "rearm");
        end
        @(posedge clk);
        pix_en <= 1'b0;
        #1;
        check(32'(valid_count - base), 32'(want), "subset size");
        check(32'(valid_count - base), 32'(g.n_valid), "subset row");
    endtask

    task automatic wrap_up();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        check(32'(out_clock_pin), 32'h0000_0000, "pin in reset");
        sys_rst <= 1'b0;
        check_reset_values();
        wb(1'b1, 8'h7c, 32'h0000_0055, 4'he);
        wb(1'b0, 8'h7c, 32'h0000_0000, 4'hf);
        check(rd, 32'h0000_004b, "sel0 low write");
        wb(1'b1, 8'h10, 32'h0000_00ff, 4'hf);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hf);
        check(rd, 32'h0000_0000, "unmapped");
        wb(1'b1, 8'h74, 32'h0000_00ff, 4'hf);
        wb(1'b0, 8'h74, 32'h0000_0000, 4'hf);
        check(rd, 32'h0000_007f, "reserved bit");
        // Black end ten short of a notional last black pixel at 15
        wb(1'b1, 8'h74, 32'h0000_0005, 4'h1);
        for (int i = 0; i < 4; i++) run_cfg(cfg[i]);
        wb(1'b0, 8'h78, 32'h0000_0000, 4'hf);
        check(rd, 32'h0000_0011, "row bands back");
        wb(1'b1, 8'hc0, 32'h0000_0000, 4'h1);
        pix_en <= 1'b1;
        @(posedge clk);
        #1;
        rd = 32'(out_clock_pin);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            #1;
            check(32'(out_clock_pin), ~rd & 32'h1, "clock toggle");
            rd = 32'(out_clock_pin);
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        pix_en <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check(32'(out_clock_pin), 32'h0000_0000, "pin after reset");
        check_reset_values();
        wrap_up();
    end
endmodule
`default_nettype wire
